// *** pkg/cardrp_pkg.sv ***
// Constants shared by the card reader/punch control latch bank.
// Assumes the microprogram drives set/reset words on the CPU clock.
package cardrp_pkg;
  localparam int          LATCH_W        = 8;
  localparam logic [3:0]  DEC_READER     = 4'hB;
  localparam logic [3:0]  DEC_PUNCH      = 4'hF;
  localparam logic [3:0]  DEC_SHARED     = 4'hD;
  localparam logic [3:0]  DEC_DIAG       = 4'h9;
  localparam logic [7:0]  LATCH_RESET    = 8'h00;
  localparam logic [7:0]  DIAG_USED_MASK = 8'h0F;
  localparam logic [7:0]  SHARED_NO_CLR  = 8'h2A;
  localparam logic [2:0]  SHIFT_LAST     = 3'h7;
  localparam logic [2:0]  SHIFT_ZERO     = 3'h0;
  localparam int          SYNC_N         = 3;
  // Reader and punch latch bit positions
  localparam int B_CHECK    = 0;
  localparam int B_FEED     = 1;
  localparam int B_STK2     = 2;
  localparam int B_STK3     = 3;
  localparam int B_VALID    = 4;
  localparam int B_SENSESET = 5;
  localparam int B_RESTART  = 5;
  localparam int B_STATUS   = 6;
  localparam int B_QUEUED   = 7;
  // Shared latch bit positions
  localparam int S_DROP_RDY = 0;
  localparam int S_COMPAT   = 1;
  localparam int S_RDR_ILK  = 2;
  localparam int S_RDR_MCHK = 3;
  localparam int S_PCH_ILK  = 4;
  localparam int S_PCH_MCHK = 5;
  localparam int S_RDR_DE   = 6;
  localparam int S_PCH_DE   = 7;
  // Diagnostic latch bit positions
  localparam int D_ENABLE   = 0;
  localparam int D_SCAN     = 1;
  localparam int D_STEP     = 2;
  localparam int D_RESET    = 3;
endpackage

// *** design/cardrp_latches.sv ***
// Control latch bank and punch data-out shifter of the reader/punch
// attachment. Set/reset words and storage loads come from the
// microprogram on CLK_IN; mechanism sense lines arrive asynchronously.
`timescale 1ns/100ps
module cardrp_latches (
  // Clock and reset
  input  wire logic                          CLK_IN,
  input  wire logic                          RST_B_IN,
  // Set/reset word from the microprogram
  input  wire logic                          SR_STROBE_IN,
  input  wire logic [3:0]                    SR_DECODE_IN,
  input  wire logic                          SR_SET_IN,
  input  wire logic [cardrp_pkg::LATCH_W-1:0] SR_MASK_IN,
  // Storage word into the punch data-out register
  input  wire logic                          PC_LOAD_IN,
  input  wire logic [cardrp_pkg::LATCH_W-1:0] PC_DATA_IN,
  // Channel side events, same clock
  input  wire logic                          RDR_END_IN,
  input  wire logic                          RDR_DE_IN,
  input  wire logic                          RDR_CMD_ACC_IN,
  input  wire logic                          RDR_DE_SENT_IN,
  input  wire logic                          PCH_END_IN,
  input  wire logic                          PCH_DE_IN,
  input  wire logic                          PCH_CMD_ACC_IN,
  input  wire logic                          PCH_DE_SENT_IN,
  // Mechanism sense lines, asynchronous
  input  wire logic                          RDR_MULTI_HOLE_IN,
  input  wire logic                          PCH_MULTI_HOLE_IN,
  input  wire logic                          SCAN_IMPULSE_IN,
  // Latch contents
  output logic [cardrp_pkg::LATCH_W-1:0]     RDR_LATCH_OUT,
  output logic [cardrp_pkg::LATCH_W-1:0]     PCH_LATCH_OUT,
  output logic [cardrp_pkg::LATCH_W-1:0]     SHARED_LATCH_OUT,
  output logic [cardrp_pkg::LATCH_W-1:0]     DIAG_LATCH_OUT,
  // Indicators and requests
  output logic                               RDR_SENSE_CLR_OUT,
  output logic                               PCH_SENSE_CLR_OUT,
  output logic                               RDR_CHECK_LAMP_OUT,
  output logic                               RDR_STATUS_REQ_OUT,
  output logic                               PCH_STATUS_REQ_OUT,
  output logic                               RDR_DEV_END_OUT,
  output logic                               PCH_DEV_END_OUT,
  // Punch data-out shifter
  output logic                               SHIFT_ADV_OUT,
  output logic                               SHIFT_RESET_OUT,
  output logic                               PCH_MAGNET_OUT
);
  import cardrp_pkg::*;

  logic [LATCH_W-1:0] rdr_reg, rdr_next;
  logic [LATCH_W-1:0] pch_reg, pch_next;
  logic [LATCH_W-1:0] shr_reg, shr_next;
  logic [LATCH_W-1:0] diag_reg, diag_next;
  logic [LATCH_W-1:0] pc_reg, pc_next;
  logic [2:0]         cnt_reg, cnt_next;
  logic               lamp_reg, lamp_next;
  logic               rdr_de_reg, rdr_de_next;
  logic [SYNC_N-1:0]  meta_reg, sync_reg;
  logic [SYNC_N-1:0]  async_in;

  // Word decode
  wire wr_rdr  = SR_STROBE_IN && (SR_DECODE_IN == DEC_READER);
  wire wr_pch  = SR_STROBE_IN && (SR_DECODE_IN == DEC_PUNCH);
  wire wr_shr  = SR_STROBE_IN && (SR_DECODE_IN == DEC_SHARED);
  wire wr_diag = SR_STROBE_IN && (SR_DECODE_IN == DEC_DIAG);
  wire [LATCH_W-1:0] rdr_set  = (wr_rdr && SR_SET_IN) ? SR_MASK_IN
                                                       : LATCH_RESET;
  wire [LATCH_W-1:0] rdr_clr  = (wr_rdr && !SR_SET_IN) ? SR_MASK_IN
                                                        : LATCH_RESET;
  wire [LATCH_W-1:0] pch_set  = (wr_pch && SR_SET_IN) ? SR_MASK_IN
                                                       : LATCH_RESET;
  wire [LATCH_W-1:0] pch_clr  = (wr_pch && !SR_SET_IN) ? SR_MASK_IN
                                                        : LATCH_RESET;
  wire [LATCH_W-1:0] shr_set  = (wr_shr && SR_SET_IN) ? SR_MASK_IN
                                                       : LATCH_RESET;
  // Zero writes to these bits have no effect
  wire [LATCH_W-1:0] shr_clr  = (wr_shr && !SR_SET_IN)
                                ? (SR_MASK_IN & ~SHARED_NO_CLR)
                                : LATCH_RESET;
  wire [LATCH_W-1:0] diag_set = (wr_diag && SR_SET_IN)
                                ? (SR_MASK_IN & DIAG_USED_MASK)
                                : LATCH_RESET;
  wire [LATCH_W-1:0] diag_clr = (wr_diag && !SR_SET_IN) ? SR_MASK_IN
                                                         : LATCH_RESET;

  // Synchronised mechanism lines
  wire rdr_multi = sync_reg[0];
  wire pch_multi = sync_reg[1];
  wire scan_pin  = sync_reg[2];

  wire diag_en   = diag_reg[D_ENABLE];
  wire diag_rst  = diag_en && diag_reg[D_RESET];
  // Step mode advances once per scan set
  wire step_mode = diag_en && diag_reg[D_STEP];
  wire step_hit  = diag_set[D_SCAN];
  wire scan_act  = diag_en ? diag_reg[D_SCAN] : scan_pin;
  wire shift_adv = !diag_rst && (step_mode ? (diag_en && step_hit)
                                           : scan_act);

  assign async_in = {SCAN_IMPULSE_IN, PCH_MULTI_HOLE_IN,
                     RDR_MULTI_HOLE_IN};

  // Two flops per asynchronous line
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g++) begin : g_sync
      always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= async_in[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  // Reader control latches; hardware sets win over clears
  always_comb begin
    rdr_next = (rdr_reg & ~rdr_clr) | rdr_set;
    // Zero on status also clears queued
    if (rdr_clr[B_STATUS]) begin
      rdr_next[B_QUEUED] = rdr_set[B_QUEUED];
    end
    if (rdr_multi) begin
      rdr_next[B_VALID] = 1'b1;
    end
    // Status at channel or device end
    if (RDR_END_IN) begin
      rdr_next[B_STATUS] = 1'b1;
    end
  end

  // Check lamp only with check latch on
  always_comb begin
    lamp_next = lamp_reg;
    if (rdr_set[B_SENSESET] && rdr_next[B_CHECK]) begin
      lamp_next = 1'b1;
    end else if (!rdr_next[B_CHECK]) begin
      lamp_next = 1'b0;
    end
  end

  // Zero on queued clears reader device end
  assign rdr_de_next = RDR_DE_IN || (rdr_de_reg && !rdr_clr[B_QUEUED]);

  // Punch control latches
  always_comb begin
    pch_next = (pch_reg & ~pch_clr) | pch_set;
    // Zero on status clears queued too
    if (pch_clr[B_STATUS]) begin
      pch_next[B_QUEUED] = pch_set[B_QUEUED];
    end
    if (pch_multi) begin
      pch_next[B_VALID] = 1'b1;
    end
    // Status at channel or device end
    if (PCH_END_IN) begin
      pch_next[B_STATUS] = 1'b1;
    end
  end

  // Shared latches
  always_comb begin
    shr_next = (shr_reg & ~shr_clr) | shr_set;
    // Interlocks follow command and device end
    if (RDR_DE_SENT_IN) begin
      shr_next[S_RDR_ILK] = 1'b0;
    end
    if (RDR_CMD_ACC_IN) begin
      shr_next[S_RDR_ILK] = 1'b1;
    end
    if (PCH_DE_SENT_IN) begin
      shr_next[S_PCH_ILK] = 1'b0;
    end
    if (PCH_CMD_ACC_IN) begin
      shr_next[S_PCH_ILK] = 1'b1;
    end
    shr_next[S_RDR_DE] = rdr_de_next;
    // Zero on punch status clears punch device end
    shr_next[S_PCH_DE] = PCH_DE_IN ||
                         (shr_reg[S_PCH_DE] && !pch_clr[B_STATUS]);
  end

  assign diag_next = (diag_reg & ~diag_clr) | diag_set;

  // Load a storage word, then shift out MSB first
  always_comb begin
    pc_next  = pc_reg;
    cnt_next = cnt_reg;
    if (diag_rst) begin
      pc_next  = LATCH_RESET;
      cnt_next = SHIFT_ZERO;
    end else if (PC_LOAD_IN) begin
      pc_next  = PC_DATA_IN;
      cnt_next = SHIFT_ZERO;
    end else if (shift_adv) begin
      pc_next  = {pc_reg[LATCH_W-2:0], 1'b0};
      cnt_next = (cnt_reg == SHIFT_LAST) ? SHIFT_ZERO
                                         : cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rdr_reg    <= LATCH_RESET;
      pch_reg    <= LATCH_RESET;
      shr_reg    <= LATCH_RESET;
      diag_reg   <= LATCH_RESET;
      pc_reg     <= LATCH_RESET;
      cnt_reg    <= SHIFT_ZERO;
      lamp_reg   <= 1'b0;
      rdr_de_reg <= 1'b0;
    end else begin
      rdr_reg    <= rdr_next;
      pch_reg    <= pch_next;
      shr_reg    <= shr_next;
      diag_reg   <= diag_next;
      pc_reg     <= pc_next;
      cnt_reg    <= cnt_next;
      lamp_reg   <= lamp_next;
      rdr_de_reg <= rdr_de_next;
    end
  end

  // Registered outputs; status requests and shift reset lag their latches by one cycle
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RDR_SENSE_CLR_OUT  <= 1'b0;
      PCH_SENSE_CLR_OUT  <= 1'b0;
      RDR_STATUS_REQ_OUT <= 1'b0;
      PCH_STATUS_REQ_OUT <= 1'b0;
      SHIFT_ADV_OUT      <= 1'b0;
      SHIFT_RESET_OUT    <= 1'b0;
    end else begin
      // Zero on reader check clears sense byte
      RDR_SENSE_CLR_OUT  <= rdr_clr[B_CHECK];
      // Zero on punch check clears sense byte
      PCH_SENSE_CLR_OUT  <= pch_clr[B_CHECK];
      RDR_STATUS_REQ_OUT <= rdr_reg[B_STATUS] && !rdr_reg[B_QUEUED];
      PCH_STATUS_REQ_OUT <= pch_reg[B_STATUS] && !pch_reg[B_QUEUED];
      SHIFT_ADV_OUT      <= shift_adv;
      SHIFT_RESET_OUT    <= diag_rst;
    end
  end

  // Feed, stacker, restart, drop-ready and compatibility bits
  // reach the mechanism through the latch outputs themselves.
  // Latches drive the mechanism
  assign RDR_LATCH_OUT      = rdr_reg;
  assign PCH_LATCH_OUT      = pch_reg;
  assign SHARED_LATCH_OUT   = shr_reg;
  assign DIAG_LATCH_OUT     = diag_reg;
  assign RDR_CHECK_LAMP_OUT = lamp_reg;
  assign RDR_DEV_END_OUT    = rdr_de_reg;
  assign PCH_DEV_END_OUT    = shr_reg[S_PCH_DE];
  assign PCH_MAGNET_OUT     = pc_reg[LATCH_W-1];

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_rdr_zero_check;
    wr_rdr && !SR_SET_IN && SR_MASK_IN[B_CHECK];
  endsequence

  a_rdr_sense_clr: assert property (
    s_rdr_zero_check |=> RDR_SENSE_CLR_OUT)
    else $error("reader sense clear missing");
  a_rdr_feed_set: assert property (
    (wr_rdr && SR_SET_IN && SR_MASK_IN[B_FEED]) |=> RDR_LATCH_OUT[B_FEED])
    else $error("reader feed not set");
  a_rdr_validity: assert property (
    $rose(rdr_multi) |=> RDR_LATCH_OUT[B_VALID])
    else $error("reader validity not set");
  a_rdr_lamp_gate: assert property (
    RDR_CHECK_LAMP_OUT |-> RDR_LATCH_OUT[B_CHECK])
    else $error("reader lamp without check");
  a_rdr_status_clr: assert property (
    (wr_rdr && !SR_SET_IN && SR_MASK_IN[B_STATUS] && !RDR_END_IN
     && !SR_MASK_IN[B_QUEUED])
    |=> !RDR_LATCH_OUT[B_STATUS] && !RDR_LATCH_OUT[B_QUEUED])
    else $error("reader status not cleared");
  a_rdr_queued_hold: assert property (
    RDR_LATCH_OUT[B_QUEUED] |=> !RDR_STATUS_REQ_OUT)
    else $error("queued reader status forwarded");
  a_pch_de_clear: assert property (
    (wr_pch && !SR_SET_IN && SR_MASK_IN[B_STATUS] && !PCH_DE_IN)
    |=> !PCH_DEV_END_OUT)
    else $error("punch device end kept");
  a_pch_queued_hold: assert property (
    PCH_LATCH_OUT[B_QUEUED] |=> !PCH_STATUS_REQ_OUT)
    else $error("queued punch status forwarded");
  a_mchk_no_clear: assert property (
    SHARED_LATCH_OUT[S_RDR_MCHK] |=> SHARED_LATCH_OUT[S_RDR_MCHK])
    else $error("machine check cleared");
  a_ilk_cmd_set: assert property (
    RDR_CMD_ACC_IN |=> SHARED_LATCH_OUT[S_RDR_ILK])
    else $error("reader interlock not set");
  a_diag_gate: assert property (
    !DIAG_LATCH_OUT[D_ENABLE] |=> !SHIFT_RESET_OUT)
    else $error("diagnostic acts without enable");
  a_diag_unused: assert property (
    (DIAG_LATCH_OUT & ~DIAG_USED_MASK) == LATCH_RESET)
    else $error("unused diagnostic bits set");
  a_pc_load_msb: assert property (
    PC_LOAD_IN && !diag_rst
    |=> PCH_MAGNET_OUT == $past(PC_DATA_IN[LATCH_W-1]))
    else $error("punch data not loaded");
  a_hold_other: assert property (
    (wr_pch && !SR_MASK_IN[B_STK2]) |=> $stable(PCH_LATCH_OUT[B_STK2]))
    else $error("unaddressed latch changed");
  a_shift_count: assert property (
    PC_LOAD_IN && !diag_rst |=> cnt_reg == SHIFT_ZERO)
    else $error("shift count not restarted");
  a_pch_validity: assert property (
    $rose(pch_multi) |=> PCH_LATCH_OUT[B_VALID])
    else $error("punch validity not set");
  a_rdr_status_set: assert property (
    RDR_END_IN |=> RDR_LATCH_OUT[B_STATUS])
    else $error("reader status not set");
  a_pch_status_set: assert property (
    PCH_END_IN |=> PCH_LATCH_OUT[B_STATUS])
    else $error("punch status not set");
  a_ilk_de_clear: assert property (
    RDR_DE_SENT_IN && !RDR_CMD_ACC_IN && !wr_shr
    |=> !SHARED_LATCH_OUT[S_RDR_ILK])
    else $error("reader interlock kept");
  a_pch_ilk_set: assert property (
    PCH_CMD_ACC_IN |=> SHARED_LATCH_OUT[S_PCH_ILK])
    else $error("punch interlock not set");
  a_diag_reset: assert property (
    diag_rst |=> SHIFT_RESET_OUT && !PCH_MAGNET_OUT)
    else $error("shifter not reset");
  a_step_hold: assert property (
    step_mode && !step_hit |=> !SHIFT_ADV_OUT)
    else $error("step mode advanced unasked");
  a_compat_hold: assert property (
    SHARED_LATCH_OUT[S_COMPAT] |=> SHARED_LATCH_OUT[S_COMPAT])
    else $error("compatibility latch cleared");
endmodule

// *** sim/card_mech.sv ***
// Far-side model: reader and punch brushes plus the scan emitter.
// Assumes the bench requests sense events on its own clock edges.
`timescale 1ns/100ps
module card_mech (
  // Bench requests and clock
  input  wire logic       clk_in,
  input  wire logic [2:0] req_in,
  // Attachment shifter output
  input  wire logic       adv_in,
  // Mechanism sense lines and shifter advance count
  output wire logic       rdr_hole_out,
  output wire logic       pch_hole_out,
  output wire logic       scan_out,
  output logic [7:0]      adv_cnt_out
);
  // Brushes lag the clock, so the lines arrive truly asynchronous
  assign #1.3 {scan_out, pch_hole_out, rdr_hole_out} = req_in;
  initial adv_cnt_out = 8'h00;
  // Counts shifter advances seen on the magnet side
  always @(posedge clk_in) begin
    if (adv_in === 1'b1) begin
      adv_cnt_out <= adv_cnt_out + 8'h01;
    end
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the reader/punch control latch bank.
// Assumes the card_mech model stands in for the mechanism lines.
`timescale 1ns/100ps
module tb_top;
  import cardrp_pkg::*;
  logic       clk, rst_b, stb, set, ld;
  logic [3:0] dec;
  logic [7:0] mask, pdata, ev;
  logic [2:0] req;
  wire        rhole, phole, scan, rclr, pclr, lamp, rsreq, psreq;
  wire        rde, pde, adv, sreset, mag;
  wire  [7:0] adv_cnt, rl, pl, sl, dl;
  int         err_count, samples_checked, cycles;

  cardrp_latches uut (
    .CLK_IN(clk), .RST_B_IN(rst_b), .SR_STROBE_IN(stb),
    .SR_DECODE_IN(dec), .SR_SET_IN(set), .SR_MASK_IN(mask),
    .PC_LOAD_IN(ld), .PC_DATA_IN(pdata),
    .RDR_END_IN(ev[0]), .RDR_DE_IN(ev[1]), .RDR_CMD_ACC_IN(ev[2]),
    .RDR_DE_SENT_IN(ev[3]), .PCH_END_IN(ev[4]), .PCH_DE_IN(ev[5]),
    .PCH_CMD_ACC_IN(ev[6]), .PCH_DE_SENT_IN(ev[7]),
    .RDR_MULTI_HOLE_IN(rhole), .PCH_MULTI_HOLE_IN(phole),
    .SCAN_IMPULSE_IN(scan), .RDR_LATCH_OUT(rl), .PCH_LATCH_OUT(pl),
    .SHARED_LATCH_OUT(sl), .DIAG_LATCH_OUT(dl),
    .RDR_SENSE_CLR_OUT(rclr), .PCH_SENSE_CLR_OUT(pclr),
    .RDR_CHECK_LAMP_OUT(lamp), .RDR_STATUS_REQ_OUT(rsreq),
    .PCH_STATUS_REQ_OUT(psreq), .RDR_DEV_END_OUT(rde),
    .PCH_DEV_END_OUT(pde), .SHIFT_ADV_OUT(adv),
    .SHIFT_RESET_OUT(sreset), .PCH_MAGNET_OUT(mag));

  card_mech mech (
    .clk_in(clk), .req_in(req), .adv_in(adv), .rdr_hole_out(rhole),
    .pch_hole_out(phole), .scan_out(scan), .adv_cnt_out(adv_cnt));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Run ceiling, well above the roughly 140 cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] d, input logic s,
                    input logic [7:0] m);
    @(posedge clk);
    {stb, dec, set, mask} <= {1'b1, d, s, m};
    @(posedge clk);
    stb <= 1'b0;
    #1;
  endtask

  // Event pulse, then one settling cycle for the registered levels
  task automatic ev_p(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    cyc(1);
  endtask

  task automatic t_reader();
    wr(DEC_READER, 1'b1, 8'h0E);
    chk(rl, 8'h0E);
    wr(DEC_READER, 1'b0, 8'h04);
    chk(rl, 8'h0A);
    wr(DEC_READER, 1'b1, 8'h20);
    cyc(2);
    chk({7'h00, lamp}, 8'h00);
    wr(DEC_READER, 1'b1, 8'h21);
    cyc(2);
    chk({7'h00, lamp}, 8'h01);
    // Sense clear pulse stands in the cycle right after the word
    wr(DEC_READER, 1'b0, 8'h2F);
    chk({7'h00, rclr}, 8'h01);
    cyc(1);
    chk({rclr, lamp, rl[5:0]}, 8'h00);
    ev_p(8'h01);
    chk({6'h00, rl[6], rsreq}, 8'h03);
    wr(DEC_READER, 1'b1, 8'h80);
    cyc(1);
    chk({7'h00, rsreq}, 8'h00);
    ev_p(8'h02);
    chk({6'h00, rde, sl[6]}, 8'h03);
    wr(DEC_READER, 1'b0, 8'h80);
    cyc(1);
    chk({6'h00, rde, sl[6]}, 8'h00);
    chk(rl, 8'h40);
    wr(DEC_READER, 1'b1, 8'h80);
    wr(DEC_READER, 1'b0, 8'h40);
    chk(rl, 8'h00);
  endtask

  task automatic t_punch();
    wr(DEC_PUNCH, 1'b1, 8'h2F);
    chk(pl, 8'h2F);
    wr(DEC_PUNCH, 1'b0, 8'h01);
    chk({pclr, pl[6:0]}, 8'hAE);
    ev_p(8'h30);
    chk({pde, psreq, pl[5:0]}, 8'hEE);
    wr(DEC_PUNCH, 1'b1, 8'h80);
    cyc(1);
    chk({7'h00, psreq}, 8'h00);
    wr(DEC_PUNCH, 1'b0, 8'h40);
    cyc(1);
    chk({4'h0, pde, sl[7], pl[7:6]}, 8'h00);
    wr(DEC_PUNCH, 1'b0, 8'h2E);
    chk(pl, 8'h00);
  endtask

  task automatic t_shared();
    wr(DEC_SHARED, 1'b1, 8'h2B);
    chk(sl, 8'h2B);
    wr(DEC_SHARED, 1'b0, 8'h2B);
    chk(sl, SHARED_NO_CLR);
    ev_p(8'h44);
    chk(sl, 8'h3E);
    ev_p(8'h88);
    chk(sl, SHARED_NO_CLR);
  endtask

  task automatic t_valid();
    @(posedge clk);
    req <= 3'b011;
    cyc(5);
    chk({6'h00, rl[4], pl[4]}, 8'h03);
    @(posedge clk);
    req <= 3'b000;
    cyc(5);
    wr(DEC_READER, 1'b0, 8'h10);
    wr(DEC_PUNCH, 1'b0, 8'h10);
    chk({6'h00, rl[4], pl[4]}, 8'h00);
  endtask

  task automatic t_shift();
    logic [7:0] base;
    @(posedge clk);
    {ld, pdata} <= {1'b1, 8'hA5};
    @(posedge clk);
    ld <= 1'b0;
    #1;
    chk({7'h00, mag}, 8'h01);
    wr(DEC_DIAG, 1'b1, 8'h05);
    base = adv_cnt;
    for (int k = 1; k < 8; k++) begin
      wr(DEC_DIAG, 1'b1, 8'h02);
      cyc(2);
      chk({7'h00, mag}, {7'h00, pdata[7-k]});
    end
    chk(adv_cnt - base, 8'h07);
    wr(DEC_DIAG, 1'b0, 8'h04);
    cyc(3);
    chk({7'h00, adv}, 8'h01);
    wr(DEC_DIAG, 1'b1, 8'h08);
    cyc(2);
    chk({6'h00, sreset, mag}, 8'h02);
    wr(DEC_DIAG, 1'b0, 8'hFF);
    // Enable off: stored bits must stay without effect
    wr(DEC_DIAG, 1'b1, 8'hFA);
    cyc(3);
    chk(dl, 8'h0A);
    chk({6'h00, sreset, adv}, 8'h00);
    wr(DEC_DIAG, 1'b0, 8'hFF);
    // Scan emitter drives shifting while diagnostics are off
    @(posedge clk);
    req <= 3'b100;
    cyc(4);
    chk({7'h00, adv}, 8'h01);
    @(posedge clk);
    req <= 3'b000;
    cyc(4);
    chk({7'h00, adv}, 8'h00);
  endtask

  initial begin
    {rst_b, stb, set, ld, dec, mask, pdata, ev, req} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    cyc(1);
    chk(rl | pl | sl | dl, LATCH_RESET);
    t_reader();
    t_punch();
    t_shared();
    t_valid();
    t_shift();
    complete_run();
  end
endmodule
